// File: tx_symbol_pkg.sv
// Constants, types and code-group tables for the 100 Mb/s transmit symbol path
package tx_symbol_pkg;

    localparam int SYM_BITS = 5;
    localparam int NIB_BITS = 4;
    localparam int LFSR_BITS = 11;
    localparam int ADDR_BITS = 5;
    localparam logic [2:0] LAST_BIT = 3'h4;

    // Line rate and the clock rates it relates to
    localparam int LINE_RATE_MBPS = 125;
    localparam int NIBBLE_RATE_MBPS = LINE_RATE_MBPS * NIB_BITS / SYM_BITS;
    localparam int CLK_MHZ = 40;

    // Control code-groups
    localparam logic [4:0] CG_IDLE = 5'h1f;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0d;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [4:0] CG_HALT = 5'h04;
    localparam logic [3:0] IDLE_NIBBLE = 4'h0;

    // Scrambler taps (x^11 + x^9 + 1) and seed layout
    localparam int TAP_HI = 10;
    localparam int TAP_LO = 8;
    localparam logic [5:0] SEED_LOW = 6'h2b;
    localparam logic [10:0] SEED_RESET = 11'h7ff;

    // MLT-3 phase: 0, +1, 0, -1
    localparam logic [1:0] MLT_POS = 2'h1;
    localparam logic [1:0] MLT_NEG = 2'h3;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_J = 3'b001,
        S_K = 3'b010,
        S_DATA = 3'b011,
        S_T = 3'b100,
        S_R = 3'b101
    } tx_state_t;

    typedef struct packed {
        logic en;
        logic er;
        logic [3:0] data;
    } mii_tx_t;

    typedef struct packed {
        logic pos;
        logic neg;
    } mlt_pair_t;

    function automatic logic [4:0] enc_nibble(input logic [3:0] n);
        case (n)
            4'h0: enc_nibble = 5'h1e;
            4'h1: enc_nibble = 5'h09;
            4'h2: enc_nibble = 5'h14;
            4'h3: enc_nibble = 5'h15;
            4'h4: enc_nibble = 5'h0a;
            4'h5: enc_nibble = 5'h0b;
            4'h6: enc_nibble = 5'h0e;
            4'h7: enc_nibble = 5'h0f;
            4'h8: enc_nibble = 5'h12;
            4'h9: enc_nibble = 5'h13;
            4'ha: enc_nibble = 5'h16;
            4'hb: enc_nibble = 5'h17;
            4'hc: enc_nibble = 5'h1a;
            4'hd: enc_nibble = 5'h1b;
            4'he: enc_nibble = 5'h1c;
            default: enc_nibble = 5'h1d;
        endcase
    endfunction : enc_nibble

    // True for a code-group that may not stand in a data field, other than 5'h10 and 5'h19
    function automatic logic bad_in_data(input logic [4:0] cg);
        case (cg)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c: bad_in_data = 1'b1;
            CG_IDLE, CG_J, CG_K, CG_T, CG_R, CG_HALT: bad_in_data = 1'b1;
            default: bad_in_data = 1'b0;
        endcase
    endfunction : bad_in_data

endpackage : tx_symbol_pkg

// File: tx_symbol_encoder.sv
// 100 Mb/s transmit path: 4B/5B encoder, scrambler, NRZI and MLT-3 split
`timescale 1ns/1ps
`default_nettype none

module tx_symbol_encoder
    import tx_symbol_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic link_clk,
    input wire mii_tx_t mii_tx,
    input wire logic [ADDR_BITS-1:0] phy_address_pins,
    input wire logic scramble_bypass,
    output logic nibble_take_reg,
    output var mlt_pair_t mlt_reg,
    output logic nrzi_reg,
    output logic code_err_reg,
    output logic frame_active_reg
);

    // Clock enable crosses into the link domain as a level
    logic ce_meta_reg;
    logic ce_link_reg;
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            ce_meta_reg <= 1'b0;
            ce_link_reg <= 1'b0;
        end else begin
            ce_meta_reg <= ce;
            ce_link_reg <= ce_meta_reg;
        end
    end

    // Address and bypass pins are static straps but still pass two flops
    logic [ADDR_BITS-1:0] addr_meta_reg;
    logic [ADDR_BITS-1:0] addr_sync_reg;
    logic byp_meta_reg;
    logic byp_sync_reg;
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            addr_meta_reg <= '0;
            addr_sync_reg <= '0;
            byp_meta_reg <= 1'b0;
            byp_sync_reg <= 1'b0;
        end else begin
            addr_meta_reg <= phy_address_pins;
            addr_sync_reg <= addr_meta_reg;
            byp_meta_reg <= scramble_bypass;
            byp_sync_reg <= byp_meta_reg;
        end
    end

    logic en_l;
    assign en_l = ce_link_reg;

    // Bit counter within a code-group; one bit per link clock
    logic [2:0] bit_cnt_reg;
    logic load;
    assign load = en_l && (bit_cnt_reg == LAST_BIT);
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            bit_cnt_reg <= 3'h0;
        end else if (en_l) begin
            bit_cnt_reg <= load ? 3'h0 : bit_cnt_reg + 3'h1;
        end
    end

    // Frame sequencing and code-group selection
    tx_state_t state_reg;
    tx_state_t state_next;
    logic [4:0] code_next;
    always_comb begin
        state_next = state_reg;
        code_next = CG_IDLE;
        unique case (state_reg)
            S_IDLE: begin
                if (mii_tx.en) begin
                    state_next = S_K;
                    code_next = CG_J;
                end else begin
                    code_next = CG_IDLE;
                end
            end
            S_J: begin
                state_next = S_K;
                code_next = CG_J;
            end
            S_K: begin
                state_next = S_DATA;
                code_next = CG_K;
            end
            S_DATA: begin
                if (!mii_tx.en) begin
                    state_next = S_R;
                    code_next = CG_T;
                end else if (mii_tx.er) begin
                    code_next = CG_HALT;
                end else begin
                    code_next = enc_nibble(mii_tx.data);
                end
            end
            S_T: begin
                state_next = S_R;
                code_next = CG_T;
            end
            S_R: begin
                state_next = S_IDLE;
                code_next = CG_R;
            end
            default: begin
                state_next = S_IDLE;
                code_next = CG_IDLE;
            end
        endcase
    end

    // One decode of "this nibble sits in a data field", shared by flag and marker
    function automatic logic data_field(input tx_state_t s, input logic en);
        data_field = (s == S_DATA) && en;
    endfunction : data_field

    logic [4:0] shift_reg;
    logic in_data_reg;
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            state_reg <= S_IDLE;
            shift_reg <= CG_IDLE;
            in_data_reg <= 1'b0;
        end else if (load) begin
            state_reg <= state_next;
            shift_reg <= code_next;
            in_data_reg <= data_field(state_reg, mii_tx.en);
        end else if (en_l) begin
            shift_reg <= {shift_reg[3:0], shift_reg[4]};
        end
    end

    // Nibble strobe to the MAC, one cycle per code-group
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            nibble_take_reg <= 1'b0;
        end else begin
            nibble_take_reg <= load;
        end
    end

    // Error flag for a control or invalid code-group other than 5'h10 and 5'h19 placed in a data field
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            code_err_reg <= 1'b0;
        end else if (load) begin
            code_err_reg <= data_field(state_reg, mii_tx.en) && bad_in_data(code_next);
        end
    end

    // Scrambler: seeded from the address once out of reset, then free running.
    // The six fixed seed bits are nonzero, so no address can park it at zero.
    logic [LFSR_BITS-1:0] lfsr_reg;
    logic seeded_reg;
    logic lfsr_fb;
    assign lfsr_fb = lfsr_reg[TAP_HI] ^ lfsr_reg[TAP_LO];
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lfsr_reg <= SEED_RESET;
            seeded_reg <= 1'b0;
        end else if (en_l) begin
            if (!seeded_reg) begin
                lfsr_reg <= {addr_sync_reg, SEED_LOW};
                seeded_reg <= 1'b1;
            end else begin
                lfsr_reg <= {lfsr_reg[LFSR_BITS-2:0], lfsr_fb};
            end
        end
    end

    logic scr_bit;
    assign scr_bit = shift_reg[4] ^ (lfsr_fb & ~byp_sync_reg);

    // NRZI then MLT-3 split; both nrzi_reg and the MLT-3 pair leave the block as line drive
    logic [1:0] mlt_phase_reg;
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            nrzi_reg <= 1'b0;
            mlt_phase_reg <= 2'h0;
            mlt_reg <= '0;
        end else if (en_l) begin
            nrzi_reg <= nrzi_reg ^ scr_bit;
            mlt_phase_reg <= mlt_phase_reg + {1'b0, scr_bit};
            mlt_reg.pos <= scr_bit ? (mlt_phase_reg + 2'h1 == MLT_POS) : (mlt_phase_reg == MLT_POS);
            mlt_reg.neg <= scr_bit ? (mlt_phase_reg + 2'h1 == MLT_NEG) : (mlt_phase_reg == MLT_NEG);
        end
    end

    // Frame activity back to the system clock as a level
    logic active_link_reg;
    logic active_meta_reg;
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            active_link_reg <= 1'b0;
        end else begin
            active_link_reg <= (state_reg != S_IDLE);
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_meta_reg <= 1'b0;
            frame_active_reg <= 1'b0;
        end else if (ce) begin
            active_meta_reg <= active_link_reg;
            frame_active_reg <= active_meta_reg;
        end
    end

    default clocking cb @(posedge link_clk); endclocking
    default disable iff (rst);

    map_nibble_a: assert property (load && state_reg == S_DATA && mii_tx.en && !mii_tx.er
        |=> shift_reg == enc_nibble($past(mii_tx.data))) else $error("data nibble misencoded");
    start_pair_a: assert property (load && state_reg == S_IDLE && mii_tx.en
        |=> shift_reg == CG_J ##5 shift_reg == CG_K) else $error("start delimiter wrong");
    end_pair_a: assert property (load && state_reg == S_DATA && !mii_tx.en
        |=> shift_reg == CG_T ##5 shift_reg == CG_R) else $error("end delimiter wrong");
    idle_fill_a: assert property (load && state_reg == S_IDLE && !mii_tx.en
        |=> shift_reg == CG_IDLE) else $error("idle missing");
    halt_sym_a: assert property (load && state_reg == S_DATA && mii_tx.en && mii_tx.er
        |=> shift_reg == CG_HALT && code_err_reg) else $error("halt missing");
    lfsr_nonzero_a: assert property (lfsr_reg != '0) else $error("scrambler all zero");
    nrzi_toggle_a: assert property (en_l |=> nrzi_reg == ($past(nrzi_reg) ^ $past(scr_bit)))
        else $error("nrzi wrong");
    mlt_split_a: assert property (!(mlt_reg.pos && mlt_reg.neg)) else $error("both mlt drives on");
    bypass_pass_a: assert property (en_l && byp_sync_reg |-> scr_bit == shift_reg[4])
        else $error("bypass not honoured");
    scramble_mix_a: assert property (en_l && !byp_sync_reg |-> scr_bit == (shift_reg[4] ^ lfsr_fb))
        else $error("scrambler xor wrong");

    // Bit timing within a code-group
    bit_wrap_a: assert property (
        en_l && bit_cnt_reg == LAST_BIT |=> bit_cnt_reg == 3'h0)
        else $error("bit counter wrap wrong");
    bit_step_a: assert property (
        en_l && bit_cnt_reg != LAST_BIT |=> bit_cnt_reg == $past(bit_cnt_reg) + 3'h1)
        else $error("bit counter step wrong");
    bit_range_a: assert property (
        bit_cnt_reg <= LAST_BIT)
        else $error("bit counter out of range");
    shift_rot_a: assert property (
        en_l && !load |=> shift_reg == {$past(shift_reg[3:0]), $past(shift_reg[4])})
        else $error("code-group not shifted out");
    take_after_a: assert property (
        load |=> nibble_take_reg)
        else $error("nibble strobe missing");
    take_pulse_a: assert property (
        nibble_take_reg |=> !nibble_take_reg)
        else $error("nibble strobe too long");

    // Clock enable low must freeze the bit counter, sequencer, scrambler and line state
    freeze_cnt_a: assert property (
        !en_l |=> $stable(bit_cnt_reg) && $stable(state_reg) && $stable(shift_reg))
        else $error("sequencer moved while frozen");
    freeze_line_a: assert property (
        !en_l |=> $stable(nrzi_reg) && $stable(mlt_reg))
        else $error("line moved while frozen");
    freeze_lfsr_a: assert property (
        !en_l |=> $stable(lfsr_reg))
        else $error("scrambler moved while frozen");

    // Frame sequencing
    start_state_a: assert property (
        load && state_reg == S_IDLE && mii_tx.en |=> state_reg == S_K)
        else $error("start not followed by K state");
    k_follows_a: assert property (
        load && state_reg == S_K |=> shift_reg == CG_K && state_reg == S_DATA)
        else $error("second start symbol wrong");
    data_stay_a: assert property (
        load && state_reg == S_DATA && mii_tx.en |=> state_reg == S_DATA)
        else $error("frame left while enabled");
    r_follows_a: assert property (
        load && state_reg == S_R |=> shift_reg == CG_R && state_reg == S_IDLE)
        else $error("second end symbol wrong");
    idle_stay_a: assert property (
        load && state_reg == S_IDLE && !mii_tx.en |=> state_reg == S_IDLE)
        else $error("idle left without enable");
    err_field_a: assert property (
        code_err_reg |-> in_data_reg)
        else $error("error flag outside data field");
    clean_data_a: assert property (
        load && state_reg == S_DATA && mii_tx.en && !mii_tx.er |=> !code_err_reg)
        else $error("error flag on clean data");

    // Scrambler stepping and seeding
    lfsr_step_a: assert property (
        en_l && seeded_reg |=> lfsr_reg == {$past(lfsr_reg[LFSR_BITS-2:0]), $past(lfsr_fb)})
        else $error("scrambler step wrong");
    seed_load_a: assert property (
        en_l && !seeded_reg |=> lfsr_reg == {$past(addr_sync_reg), SEED_LOW})
        else $error("scrambler seed wrong");

    // Line coding levels
    nrzi_hold_a: assert property (
        en_l && !scr_bit |=> $stable(nrzi_reg))
        else $error("nrzi moved on a zero");
    mlt_pos_a: assert property (
        mlt_reg.pos |-> mlt_phase_reg == MLT_POS)
        else $error("positive drive in wrong phase");
    mlt_neg_a: assert property (
        mlt_reg.neg |-> mlt_phase_reg == MLT_NEG)
        else $error("negative drive in wrong phase");
    mlt_zero_a: assert property (
        !mlt_reg.pos && !mlt_reg.neg |-> !mlt_phase_reg[0])
        else $error("zero level in wrong phase");

endmodule : tx_symbol_encoder

`default_nettype wire

// File: tx_mac_model.sv
// MAC side model feeding transmit nibbles whenever the encoder takes one
`timescale 1ns/1ps
`default_nettype none
module tx_mac_model
    import tx_symbol_pkg::*;
(
    input wire logic link_clk,
    input wire logic rst,
    input wire logic nibble_take_reg,
    output var mii_tx_t mii_tx
);
    mii_tx_t q[$];

    task automatic push(input mii_tx_t v);
        q.push_back(v);
    endtask : push

    // A new nibble appears only after the previous one was taken
    always @(posedge link_clk or posedge rst) begin
        if (rst) begin
            mii_tx <= '0;
        end else if (nibble_take_reg) begin
            if (q.size() > 0) begin
                mii_tx <= q.pop_front();
            end else begin
                // Idle data lines toggle so a stale nibble cannot pass for fresh data
                mii_tx <= {2'b00, ~mii_tx.data};
            end
        end
    end
endmodule : tx_mac_model
`default_nettype wire

// File: test_tx_symbol_encoder.sv
// Self-checking bench for the transmit symbol encoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin n_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_tx_symbol_encoder;
    import tx_symbol_pkg::*;
    logic clk, link_clk, rst, ce, scramble_bypass, nibble_take_reg, nrzi_reg, code_err_reg, frame_active_reg;
    logic [ADDR_BITS-1:0] phy_address_pins;
    mii_tx_t mii_tx;
    mlt_pair_t mlt_reg, prev_mlt;
    int n_errors = 0, cmp_count = 0, frames = 0, nb;
    logic [4:0] tbl [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    logic [4:0] exp_q[$];
    logic [4:0] grp, eg;
    logic [14:0] win;
    logic [2:0] held;
    logic prev_nrzi, bit_d, in_frame, last_pos, saw_err, saw_act, scr_on;
    bit ks[$];

    tx_symbol_encoder u_tx_symbol_encoder (.clk(clk), .rst(rst), .ce(ce), .link_clk(link_clk),
        .mii_tx(mii_tx), .phy_address_pins(phy_address_pins), .scramble_bypass(scramble_bypass),
        .nibble_take_reg(nibble_take_reg), .mlt_reg(mlt_reg), .nrzi_reg(nrzi_reg),
        .code_err_reg(code_err_reg), .frame_active_reg(frame_active_reg));
    tx_mac_model u_tx_mac_model (.link_clk(link_clk), .rst(rst), .nibble_take_reg(nibble_take_reg),
        .mii_tx(mii_tx));

    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    // Link clock offset so its edges never line up with rising edges of the system clock
    initial begin
        link_clk = 0;
        #7;
        forever #16 link_clk = ~link_clk;
    end

    always @(posedge clk) if (frame_active_reg === 1'b1) saw_act = 1;
    always @(posedge link_clk) if (code_err_reg === 1'b1) saw_err = 1;

    // Line decoder: recovers code bits from NRZI and checks the MLT-3 pair
    always @(posedge link_clk) begin
        if (rst) begin
            prev_nrzi = 0;
            prev_mlt = '0;
            in_frame = 0;
            win = '0;
            last_pos = 0;
        end else begin
            bit_d = nrzi_reg ^ prev_nrzi;
            prev_nrzi = nrzi_reg;
            `CHK("mlt_both", 1'b0, mlt_reg.pos & mlt_reg.neg)
            `CHK("mlt_step", bit_d, mlt_reg !== prev_mlt)
            if ((mlt_reg.pos | mlt_reg.neg) && mlt_reg !== prev_mlt) begin
                `CHK("mlt_alt", ~last_pos, mlt_reg.pos)
                last_pos = mlt_reg.pos;
            end
            prev_mlt = mlt_reg;
            if (scr_on) ks.push_back(~bit_d);
            win = {win[13:0], bit_d};
            if (in_frame) begin
                grp = {grp[3:0], bit_d};
                nb++;
                if (nb == 5) begin
                    nb = 0;
                    eg = exp_q.pop_front();
                    `CHK("code_group", eg, grp)
                    if (exp_q.size() == 0) begin
                        in_frame = 0;
                        frames++;
                    end
                end
            end else if (exp_q.size() > 0 && win == {CG_IDLE, CG_J, CG_K}) begin
                in_frame = 1;
                nb = 0;
            end
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize

    // One frame: six preamble nibbles then a run that walks all sixteen values
    task automatic send(input int n, input int er_at);
        int f0, k;
        logic [3:0] r;
        mii_tx_t v;
        saw_err = 0;
        saw_act = 0;
        f0 = frames;
        r = 4'($urandom);
        for (int i = 0; i < n; i++) begin
            v.en = 1'b1;
            v.er = (i == er_at);
            v.data = (i < 6) ? 4'h5 : 4'(r + i);
            if (i >= 2) exp_q.push_back(v.er ? CG_HALT : tbl[v.data]);
            u_tx_mac_model.push(v);
        end
        exp_q.push_back(CG_T);
        exp_q.push_back(CG_R);
        exp_q.push_back(CG_IDLE);
        for (k = 0; k < 3000 && frames == f0; k++) @(posedge link_clk);
        `CHK("frame_seen", f0 + 1, frames)
        `CHK("halt_flag", 1'(er_at >= 0), saw_err)
        `CHK("active_seen", 1'b1, saw_act)
        $display("frame of %0d nibbles done", n);
    endtask : send

    initial begin
        void'($urandom(32'h150e));
        rst = 1;
        ce = 1;
        scramble_bypass = 1;
        scr_on = 0;
        phy_address_pins = 5'($urandom);
        repeat (5) @(posedge clk);
        rst <= 0;
        repeat (20) @(posedge link_clk);
        send(24, -1);
        // Clock enable low between frames must freeze the line
        @(posedge clk);
        ce <= 0;
        repeat (5) @(posedge link_clk);
        held = {nrzi_reg, mlt_reg};
        repeat (20) @(posedge link_clk);
        `CHK("ce_hold", held, {nrzi_reg, mlt_reg})
        @(posedge clk);
        ce <= 1;
        repeat (40) @(posedge link_clk);
        $display("clock enable test done");
        send(23, 9);
        @(posedge clk);
        scramble_bypass <= 0;
        repeat (40) @(posedge link_clk);
        ks.delete();
        scr_on = 1;
        repeat (80) @(posedge link_clk);
        scr_on = 0;
        // Idle is all ones, so the line carries the inverted LFSR sequence
        for (int t = 11; t < ks.size(); t++) `CHK("keystream", ks[t-11] ^ ks[t-9], ks[t])
        `CHK("ks_live", 1'b1, ks.or())
        $display("scrambler test done");
        @(posedge clk);
        scramble_bypass <= 1;
        repeat (40) @(posedge link_clk);
        send(22, 20);
        summarize();
    end

    // Far beyond the several hundred link cycles the tests need
    initial begin
        #300000;
        n_errors++;
        summarize();
    end
endmodule : test_tx_symbol_encoder
`default_nettype wire
